// ==== ccu_capture_unit.sv ====
// capture unit with its control register, compare hooks and bridge select
// assumes a single 100 MHz clock, synchronous reset, a plain register port
// and an external timer one / timer two supplied as inputs
// How it works
// - capture copies full 16-bit timer one value
// - four event choices: fall, rise, 4th, 16th
// - each capture sets flag bit 2
// - new capture overwrites unread result
// - edges seen on pin level, any direction
// - mode change may raise spurious flag
// - prescaler cleared when off or not capturing
// - direct prescaler switch keeps counter
// - capture/compare use timer one, pwm timer two
// - bits 5-4 hold duty low bits
// - two-bit field selects bridge arrangement
// - half bridge modulates a and b only
// - compare codes set, clear, interrupt on match
// - code 1011 resets timer, starts converter
`timescale 1ns/1ps
`include "ccu_consts.svh"
module ccu_capture_unit
  import ccu_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire logic [`CCU_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // pin and timers
  input wire logic capture_pin,
  input wire logic [15:0] general_timer_one,
  input wire logic [7:0] period_timer_two,
  input wire logic pwm_wave,
  input wire logic converter_enabled,
  // outputs
  output logic capture_event_flag,
  output logic capture_irq,
  output logic timer_one_reset,
  output logic converter_start,
  output logic compare_out,
  output logic bridge_out_a,
  output logic bridge_out_b,
  output logic bridge_out_c,
  output logic bridge_out_d,
  output logic bridge_c_is_port,
  output logic bridge_d_is_port
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] unit_control_reg;
  logic [15:0] capture_result_pair_reg;
  logic capture_event_enable_reg;
  logic flag_reg;
  logic [3:0] presc_reg;
  logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [7:0] rdata_reg;
  logic cmp_out_reg;
  logic [3:0] bridge_reg;
  logic tmr_rst_reg, conv_reg;
  ccu_state_t state;

  logic [3:0] unit_mode_field;
  logic [1:0] duty_low_bits;
  logic [1:0] bridge_output_config;
  logic is_capture, rise, fall, cap_event, cmp_match, cmp_mode, pwm_mode;
  logic flag_clear;

  assign unit_mode_field = unit_control_reg[`CCU_MODE_MSB:`CCU_MODE_LSB];
  assign duty_low_bits = unit_control_reg[`CCU_DUTY_MSB:`CCU_DUTY_LSB];
  assign bridge_output_config =
    unit_control_reg[`CCU_BRIDGE_MSB:`CCU_BRIDGE_LSB];
  assign is_capture = (unit_mode_field >= `CCU_M_CAP_FALL) &&
                      (unit_mode_field <= `CCU_M_CAP_R16);
  assign cmp_mode = (unit_mode_field >= `CCU_M_CMP_SET) &&
                    (unit_mode_field <= `CCU_M_CMP_SPEC);
  assign pwm_mode = unit_mode_field[3:2] == `CCU_M_PWM_HI;

  always_comb begin
    if (unit_mode_field == `CCU_M_OFF) begin
      state = CCU_ST_OFF;
    end else if (is_capture) begin
      state = CCU_ST_CAPTURE;
    end else begin
      state = CCU_ST_OTHER;
    end
  end

  // ------------------------------------------------------------
  // pin synchroniser and edge detect
  // ------------------------------------------------------------
  // the pin is sampled whatever its direction, so a port write that
  // drives it can itself cause a capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else if (clk_en) begin
      pin_meta_reg <= capture_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end
  assign rise = pin_sync_reg && !pin_prev_reg;
  assign fall = !pin_sync_reg && pin_prev_reg;

  // ------------------------------------------------------------
  // prescaler and event selection
  // ------------------------------------------------------------
  // the counter only clears when capture is left; switching between
  // prescaled modes directly keeps the count
  always_ff @(posedge mclk) begin
    if (reset) begin
      presc_reg <= 4'h0;
    end else if (clk_en) begin
      if (state != CCU_ST_CAPTURE) begin
        presc_reg <= 4'h0;
      end else if (rise) begin
        presc_reg <= presc_reg + 4'h1;
      end
    end
  end

  always_comb begin
    case (unit_mode_field)
      `CCU_M_CAP_FALL: cap_event = fall;
      `CCU_M_CAP_RISE: cap_event = rise;
      `CCU_M_CAP_R4:
        cap_event = rise && (presc_reg[1:0] == `CCU_PS_R4_LAST);
      `CCU_M_CAP_R16: cap_event = rise && (presc_reg == `CCU_PS_R16_LAST);
      default: cap_event = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // capture result and compare
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_result_pair_reg <= 16'h0000;
    end else if (clk_en) begin
      if (cap_event) begin
        // overwrite regardless of whether software read the last value
        capture_result_pair_reg <= general_timer_one;
      end else if (reg_write && reg_addr == `CCU_OFF_RES_LO) begin
        capture_result_pair_reg[7:0] <= reg_wdata;
      end else if (reg_write && reg_addr == `CCU_OFF_RES_HI &&
                   !pwm_mode) begin
        capture_result_pair_reg[15:8] <= reg_wdata;
      end
    end
  end

  assign cmp_match = cmp_mode &&
                     (general_timer_one == capture_result_pair_reg);

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_out_reg <= 1'b0;
      tmr_rst_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else if (clk_en) begin
      tmr_rst_reg <= cmp_match && unit_mode_field == `CCU_M_CMP_SPEC;
      conv_reg <= cmp_match && unit_mode_field == `CCU_M_CMP_SPEC &&
                  converter_enabled;
      if (unit_mode_field == `CCU_M_OFF) begin
        cmp_out_reg <= 1'b0;
      end else if (cmp_match && unit_mode_field == `CCU_M_CMP_SET) begin
        cmp_out_reg <= 1'b1;
      end else if (cmp_match && unit_mode_field == `CCU_M_CMP_CLR) begin
        cmp_out_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // flag, enable and control register
  // ------------------------------------------------------------
  assign flag_clear = reg_write && reg_addr == `CCU_OFF_FLAG &&
                      !reg_wdata[`CCU_FLAG_BIT];

  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (clk_en) begin
      // a spurious event during a mode change sets it too; the set wins
      if (cap_event || cmp_match) begin
        flag_reg <= 1'b1;
      end else if (flag_clear) begin
        flag_reg <= 1'b0;
      end else if (reg_write && reg_addr == `CCU_OFF_FLAG) begin
        flag_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      unit_control_reg <= `CCU_CTRL_RESET;
      capture_event_enable_reg <= 1'b0;
    end else if (clk_en && reg_write) begin
      if (reg_addr == `CCU_OFF_CTRL) begin
        unit_control_reg <= reg_wdata;
      end else if (reg_addr == `CCU_OFF_ENABLE) begin
        capture_event_enable_reg <= reg_wdata[`CCU_FLAG_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // bridge outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      bridge_reg <= 4'h0;
    end else if (clk_en) begin
      if (!pwm_mode) begin
        bridge_reg <= {3'h0, cmp_out_reg};
      end else begin
        case (bridge_output_config)
          `CCU_BR_SINGLE: bridge_reg <= {3'h0, pwm_wave};
          `CCU_BR_FULL_FWD: bridge_reg <= {pwm_wave, 2'h0, 1'b1};
          `CCU_BR_HALF: bridge_reg <= {2'h0, !pwm_wave, pwm_wave};
          `CCU_BR_FULL_REV: bridge_reg <= {1'b0, 1'b1, pwm_wave, 1'b0};
          default: bridge_reg <= 4'h0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      if (!reg_read) begin
        rdata_reg <= 8'h00;
      end else if (reg_addr == `CCU_OFF_CTRL) begin
        rdata_reg <= unit_control_reg;
      end else if (reg_addr == `CCU_OFF_RES_LO) begin
        rdata_reg <= capture_result_pair_reg[7:0];
      end else if (reg_addr == `CCU_OFF_RES_HI) begin
        rdata_reg <= capture_result_pair_reg[15:8];
      end else if (reg_addr == `CCU_OFF_FLAG) begin
        rdata_reg <= {5'h00, flag_reg, 2'h0};
      end else if (reg_addr == `CCU_OFF_ENABLE) begin
        rdata_reg <= {5'h00, capture_event_enable_reg, 2'h0};
      end else if (reg_addr == `CCU_OFF_OUTS) begin
        rdata_reg <= {4'h0, bridge_reg};
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign capture_event_flag = flag_reg;
  assign capture_irq = flag_reg && capture_event_enable_reg;
  assign timer_one_reset = tmr_rst_reg;
  assign converter_start = conv_reg;
  assign compare_out = cmp_out_reg;
  assign bridge_out_a = bridge_reg[0];
  assign bridge_out_b = bridge_reg[1];
  assign bridge_out_c = bridge_reg[2];
  assign bridge_out_d = bridge_reg[3];
  // only the two full-bridge codes take c and d away from the port
  assign bridge_c_is_port = !pwm_mode || !bridge_output_config[0];
  assign bridge_d_is_port = !pwm_mode || !bridge_output_config[0];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // every check shares the one clock and is off while reset is high
  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence rise_seen;
    (clk_en && !pin_sync_reg) ##1 pin_sync_reg;
  endsequence

  sequence fall_seen;
    (clk_en && pin_sync_reg) ##1 !pin_sync_reg;
  endsequence

  capture_latch_a: assert property (
    clk_en && cap_event |=>
      capture_result_pair_reg == $past(general_timer_one))
    else $error("capture did not latch timer value");
  capture_flag_a: assert property (
    clk_en && cap_event |=> flag_reg)
    else $error("capture did not set flag");
  flag_sticky_a: assert property (
    flag_reg && !(clk_en && flag_clear) |=> flag_reg)
    else $error("flag dropped without software clear");
  flag_clear_a: assert property (
    clk_en && flag_clear && !cap_event && !cmp_match |=> !flag_reg)
    else $error("software clear of flag ignored");
  presc_clear_a: assert property (
    clk_en && !is_capture |=> presc_reg == 4'h0)
    else $error("prescaler not cleared outside capture");
  presc_keep_a: assert property (
    clk_en && is_capture && !rise |=> presc_reg == $past(presc_reg))
    else $error("prescaler changed without a rising edge");
  rise_event_a: assert property (
    unit_mode_field == `CCU_M_CAP_RISE && rise |-> cap_event)
    else $error("rising edge missed");
  fall_event_a: assert property (
    unit_mode_field == `CCU_M_CAP_FALL && fall |-> cap_event)
    else $error("falling edge missed");
  pin_edge_a: assert property (
    rise_seen |-> rise)
    else $error("synchronised rise not detected");
  pin_fall_a: assert property (
    fall_seen |-> fall)
    else $error("synchronised fall not detected");
  spec_event_a: assert property (
    clk_en && cmp_match && unit_mode_field == `CCU_M_CMP_SPEC
      |=> timer_one_reset && flag_reg)
    else $error("special event missing");
  cmp_set_a: assert property (
    clk_en && cmp_match && unit_mode_field == `CCU_M_CMP_SET |=> compare_out)
    else $error("compare set failed");
  cmp_clear_a: assert property (
    clk_en && cmp_match && unit_mode_field == `CCU_M_CMP_CLR |=> !compare_out)
    else $error("compare clear failed");
  half_ports_a: assert property (
    pwm_mode && bridge_output_config == `CCU_BR_HALF
      |-> bridge_c_is_port && bridge_d_is_port)
    else $error("half bridge took c or d from the port");
endmodule

// ==== ccu_consts.svh ====
// constants for the capture unit and its control register
// assumes inclusion by the design file and the bench only
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH
`define CCU_ADDR_W 3
`define CCU_OFF_CTRL 3'h0
`define CCU_OFF_RES_LO 3'h1
`define CCU_OFF_RES_HI 3'h2
`define CCU_OFF_FLAG 3'h3
`define CCU_OFF_ENABLE 3'h4
`define CCU_OFF_OUTS 3'h5
`define CCU_FLAG_BIT 2
`define CCU_CTRL_RESET 8'h00
`define CCU_MODE_LSB 0
`define CCU_MODE_MSB 3
`define CCU_DUTY_LSB 4
`define CCU_DUTY_MSB 5
`define CCU_BRIDGE_LSB 6
`define CCU_BRIDGE_MSB 7
`define CCU_M_OFF 4'h0
`define CCU_M_TOGGLE 4'h2
`define CCU_M_CAP_FALL 4'h4
`define CCU_M_CAP_RISE 4'h5
`define CCU_M_CAP_R4 4'h6
`define CCU_M_CAP_R16 4'h7
`define CCU_M_CMP_SET 4'h8
`define CCU_M_CMP_CLR 4'h9
`define CCU_M_CMP_SWI 4'hA
`define CCU_M_CMP_SPEC 4'hB
`define CCU_M_PWM_HI 2'h3
`define CCU_PS_R4_LAST 2'h3
`define CCU_PS_R16_LAST 4'hF
`define CCU_BR_SINGLE 2'h0
`define CCU_BR_FULL_FWD 2'h1
`define CCU_BR_HALF 2'h2
`define CCU_BR_FULL_REV 2'h3
`endif

// ==== ccu_pkg.sv ====
// types shared by the capture unit
// assumes ccu_consts.svh sits in the same folder
package ccu_pkg;
  typedef enum logic [2:0] {
    CCU_ST_OFF = 3'b001,
    CCU_ST_CAPTURE = 3'b010,
    CCU_ST_OTHER = 3'b100
  } ccu_state_t;
endpackage

// ==== ccu_pin_source.sv ====
// external signal source that drives the capture pin of the unit
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module ccu_pin_source (
  // clock
  input wire logic mclk,
  // pin
  output logic capture_pin
);
  initial capture_pin = 1'h0;

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // the pin is driven as a plain input level, never shared
  task automatic set_level(input logic v);
    @(posedge mclk);
    capture_pin <= v;
  endtask

  // w sets how slow the edges come; even at 1 the sync stages see every level
  task automatic pulses(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      set_level(1'h1);
      repeat (w) @(posedge mclk);
      capture_pin <= 1'h0;
      repeat (w) @(posedge mclk);
    end
  endtask
endmodule

// ==== ccu_capture_unit_tb.sv ====
// self-checking bench for the capture unit and its control register
// assumes ccu_pin_source drives the pin and the bench owns the timers
`timescale 1ns/1ps
`include "ccu_consts.svh"
module ccu_capture_unit_tb;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic capture_pin;
  // timer one moves on a clock edge, or 1 ns after one when set straight after a read
  logic [15:0] timer;
  logic conv_en;
  logic flag;
  logic irq;
  logic t1_rst;
  logic conv_go;
  logic cmp_out;
  logic c_port;
  logic d_port;
  logic [7:0] rv;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 mclk = ~mclk;

  ccu_pin_source src (.mclk(mclk), .capture_pin(capture_pin));

  ccu_capture_unit i_dut (
    .mclk(mclk), .reset(reset), .clk_en(1'h1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .capture_pin(capture_pin), .general_timer_one(timer),
    .period_timer_two(8'h00), .pwm_wave(1'h0),
    .converter_enabled(conv_en), .capture_event_flag(flag),
    .capture_irq(irq), .timer_one_reset(t1_rst),
    .converter_start(conv_go), .compare_out(cmp_out),
    .bridge_out_a(), .bridge_out_b(), .bridge_out_c(), .bridge_out_d(),
    .bridge_c_is_port(c_port), .bridge_d_is_port(d_port)
  );

  // ------------------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge mclk);
    reg_write <= 1'h0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge mclk);
    reg_read <= 1'h0;
    // read data stand only until the next edge; take them settled
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask

  task automatic chk_result(input logic [15:0] e);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(`CCU_OFF_RES_LO, lo);
    rd(`CCU_OFF_RES_HI, hi);
    chk("result", e, {hi, lo});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(`CCU_OFF_CTRL, rv);
    chk("ctrl reset", {8'h00, `CCU_CTRL_RESET}, {8'h00, rv});
    rd(`CCU_OFF_FLAG, rv);
    chk("flag reset", 16'h0000, {8'h00, rv});
    wr(3'h7, 8'hFF);
    rd(3'h7, rv);
    chk("unmapped", 16'h0000, {8'h00, rv});
  endtask

  task automatic t_bridge();
    for (int c = 0; c < 4; c++) begin
      wr(`CCU_OFF_CTRL, {c[1:0], 6'h2C});
      rd(`CCU_OFF_CTRL, rv);
      chk("ctrl rw", {8'h00, c[1:0], 6'h2C}, {8'h00, rv});
      chk("c port", {15'h0, c[0] == 1'h0}, {15'h0, c_port});
      chk("d port", {15'h0, c[0] == 1'h0}, {15'h0, d_port});
    end
    wr(`CCU_OFF_CTRL, 8'h00);
  endtask

  // pre pulses load the prescaler, which turning off must clear
  task automatic cap_count(input logic [3:0] m, input int n, input int pre);
    timer <= 16'h1111;
    wr(`CCU_OFF_CTRL, {4'h0, m});
    src.pulses(pre, 4);
    wr(`CCU_OFF_CTRL, 8'h00);
    wr(`CCU_OFF_CTRL, {4'h0, m});
    wr(`CCU_OFF_FLAG, 8'h00);
    src.pulses(n - 1, 4);
    chk("early flag", 16'h0000, {15'h0, flag});
    timer <= {4'hC, m, 8'h5A};
    src.pulses(1, 4);
    chk("flag", 16'h0001, {15'h0, flag});
    chk_result({4'hC, m, 8'h5A});
  endtask

  task automatic t_fall();
    wr(`CCU_OFF_CTRL, {4'h0, `CCU_M_CAP_FALL});
    wr(`CCU_OFF_FLAG, 8'h00);
    timer <= 16'h3C69;
    src.set_level(1'h1);
    repeat (6) @(posedge mclk);
    chk("rise ignored", 16'h0000, {15'h0, flag});
    src.set_level(1'h0);
    repeat (6) @(posedge mclk);
    chk_result(16'h3C69);
    repeat (20) @(posedge mclk);
    rd(`CCU_OFF_FLAG, rv);
    chk("flag held", 16'h0004, {8'h00, rv & 8'h04});
    wr(`CCU_OFF_ENABLE, 8'h04);
    @(posedge mclk);
    chk("irq", 16'h0001, {15'h0, irq});
    wr(`CCU_OFF_FLAG, 8'h00);
    @(posedge mclk);
    chk("irq clear", 16'h0000, {15'h0, irq});
    wr(`CCU_OFF_ENABLE, 8'h00);
  endtask

  task automatic t_overwrite();
    wr(`CCU_OFF_CTRL, {4'h0, `CCU_M_CAP_RISE});
    timer <= 16'h1357;
    src.pulses(1, 4);
    timer <= 16'hFEDC;
    src.pulses(1, 4);
    chk_result(16'hFEDC);
  endtask

  task automatic cmp_code(input logic [3:0] m);
    logic seen_rst;
    logic seen_go;
    seen_rst = 1'h0;
    seen_go = 1'h0;
    wr(`CCU_OFF_CTRL, 8'h00);
    wr(`CCU_OFF_RES_LO, 8'h34);
    wr(`CCU_OFF_RES_HI, 8'h12);
    timer <= 16'h0000;
    conv_en <= 1'h1;
    wr(`CCU_OFF_CTRL, {4'h0, m});
    wr(`CCU_OFF_FLAG, 8'h00);
    timer <= 16'h1234;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      seen_rst = seen_rst | (t1_rst === 1'h1);
      seen_go = seen_go | (conv_go === 1'h1);
    end
    chk("cmp flag", 16'h0001, {15'h0, flag});
    chk("t1 reset", {15'h0, m == 4'hB}, {15'h0, seen_rst});
    chk("conv start", {15'h0, m == 4'hB}, {15'h0, seen_go});
    if (m == `CCU_M_CMP_SET)
      chk("cmp out", 16'h0001, {15'h0, cmp_out});
    timer <= 16'h0000;
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'h0;
    reg_read = 1'h0;
    timer = 16'h0000;
    conv_en = 1'h0;
    repeat (10) @(posedge mclk);
    reset <= 1'h0;
    t_reset();
    t_bridge();
    cap_count(`CCU_M_CAP_RISE, 1, 0);
    cap_count(`CCU_M_CAP_R4, 4, 2);
    cap_count(`CCU_M_CAP_R16, 16, 1);
    t_fall();
    t_overwrite();
    for (int m = 8; m < 12; m++) begin
      cmp_code(m[3:0]);
    end
    end_sim();
  end
endmodule
